/* core/bfr_line_coder.sv */
// bfr_line_coder: bipolar line coder with hdb3 substitution, ais and bpv insert
// assumes: one bit per tx_line_valid pulse, same clock as the register bank
`timescale 1ns/1ps
module bfr_line_coder (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic line_valid,
  input  wire logic line_bit,
  input  wire logic hdb3_en,
  input  wire logic ones_en,
  input  wire logic bpv_req,
  output logic      bpv_done,
  output logic      line_pos,
  output logic      line_neg
);
  localparam int D = bfr_pkg::HDB3_DEPTH;
  logic [D-1:0] sh, b_mk, v_mk;
  logic [D-1:0] next_sh, next_b_mk, next_v_mk;
  logic [1:0]   ones_run, next_ones_run;
  logic         last_pol, next_last_pol, par_odd, next_par_odd;
  logic         next_pos, next_neg;

  always_comb begin
    next_sh       = sh;
    next_b_mk     = b_mk;
    next_v_mk     = v_mk;
    next_ones_run = ones_run;
    next_last_pol = last_pol;
    next_par_odd  = par_odd;
    next_pos      = line_pos;
    next_neg      = line_neg;
    bpv_done      = 1'b0;
    if (line_valid) begin
      next_sh   = {sh[D-2:0], line_bit | ones_en};
      next_b_mk = {b_mk[D-2:0], 1'b0};
      next_v_mk = {v_mk[D-2:0], 1'b0};
      // four zeros become 000V or B00V, B00V when par_odd is 0, the pulse sent in this same cycle not yet counted
      if (hdb3_en && !ones_en && next_sh == '0 && next_v_mk == '0 && next_b_mk == '0) begin // [RL6]
        next_v_mk[0]   = 1'b1;
        next_b_mk[D-1] = !par_odd;
      end
      next_pos = 1'b0;
      next_neg = 1'b0;
      if (v_mk[D-1]) begin
        next_pos     = last_pol;
        next_neg     = !last_pol;
        next_par_odd = 1'b0;
        next_ones_run = '0;
      end else if (sh[D-1] || b_mk[D-1]) begin
        // third one in a row carries the requested violation
        if (bpv_req && ones_run == 2'(bfr_pkg::ONES_RUN) && sh[D-1]) begin // [RL3]
          next_pos = last_pol;
          next_neg = !last_pol;
          bpv_done = 1'b1;
        end else begin
          next_pos      = !last_pol;
          next_neg      = last_pol;
          next_last_pol = !last_pol;
        end
        next_par_odd  = !par_odd;
        next_ones_run = (ones_run == 2'(bfr_pkg::ONES_RUN)) ? ones_run : ones_run + 2'd1;
      end else begin
        next_ones_run = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sh       <= '0;
      b_mk     <= '0;
      v_mk     <= '0;
      ones_run <= '0;
      last_pol <= 1'b0;
      par_odd  <= 1'b0;
      line_pos <= 1'b0;
      line_neg <= 1'b0;
    end else begin
      sh       <= next_sh;
      b_mk     <= next_b_mk;
      v_mk     <= next_v_mk;
      ones_run <= next_ones_run;
      last_pol <= next_last_pol;
      par_odd  <= next_par_odd;
      line_pos <= next_pos;
      line_neg <= next_neg;
    end
  end
endmodule // bfr_line_coder

/* core/bfr_pkg.sv */
// bfr_pkg: register map, field positions and widths for the framer slice
// assumes: 8-bit register port, single clock domain
package bfr_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_TX_CONFIG_COMMON  = 8'h29;
  localparam logic [7:0] OFS_TX_CONFIG_E1      = 8'h2A;
  localparam logic [7:0] OFS_RX_IRQ_SUMMARY    = 8'h30;
  localparam logic [7:0] OFS_RX_LIVE_ALARMS    = 8'h31;
  localparam logic [7:0] OFS_RX_E1_SYNC_INFO   = 8'h32;
  localparam logic [7:0] OFS_RX_LATCHED_ALARMS = 8'h33;
  localparam logic [7:0] OFS_RX_IRQ_ENABLE_ONE = 8'h34;
  localparam logic [7:0] RESET_BYTE            = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_FRAMING_SELECT   = 2;
  localparam int BIT_VIOLATION_INSERT = 1;
  localparam int BIT_SLOT0_PASS       = 7;
  localparam int BIT_INTL_SOURCE      = 4;
  localparam int BIT_LINE_CODE_EN     = 2;
  localparam int BIT_ALARM_ONES       = 1;
  localparam int BIT_MF_CHECK_EN      = 0;
  localparam int BIT_SUM_STATUS_FOUR  = 6;
  localparam int BIT_SUM_STATUS_THREE = 1;
  localparam int BIT_SUM_STATUS_ONE   = 0;
  localparam int BIT_SEARCH_FRAME     = 2;
  localparam int BIT_SEARCH_SIG_MF    = 1;
  localparam int BIT_SEARCH_CHECK_MF  = 0;
  localparam int LSB_GONE_FIELD       = 4;
  localparam int LSB_COUNT_FIELD      = 3;
  // bit 7 counted msb-first from 1, i.e. second lsb of the byte
  localparam int BIT_ZERO_STUFF       = 1;
  localparam int BIT_SI               = 7;

  // ************************************************************
  // masks and widths
  // ************************************************************
  localparam logic [7:0] MASK_TX_COMMON = 8'h06;
  localparam logic [7:0] MASK_TX_E1     = 8'h97;
  localparam int         CSC_W          = 6;
  localparam int         ALARM_N        = 4;
  localparam int         ONES_RUN       = 2;
  localparam int         HDB3_DEPTH     = 4;
  localparam logic [7:0] ALL_ONES_BYTE  = 8'hFF;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
endpackage

/* core/bfr_regs.sv */
// bfr_regs: transmit formatter options, receive alarm status and summary
// assumes: register port and all framer inputs are synchronous to mclk
// Operation
// RL1: zero channel byte gets bit 7 set; code never does, mask 06h keeps enable bit 0 at 0
// RL2: framing bit: 0 ESF, 1 SF; E1 keeps 0
// RL3: violation bit rise inserts one BPV at ones-run
// RL4: slot0 pass-through picks registers or serial input
// RL5: Si bits from serial input or registers
// RL6: E1 HDB3 enable selects HDB3 line coding
// RL7: E1 alarm bit sends unframed all ones
// RL8: E1 CRC-4 enable generates multiframe check
// RL9: summary bits 6,1,0 flag pending status
// RL10: summary clears when status register empties
// RL11: masked status bits ignored by summary
// RL12: live alarms RAI, AIS, LOS, OOF readable
// RL13: sync counter counts expired CRC-4 searches
// RL14: counter clears on sync or CRC-4 off
// RL15: six-bit wrapping counter, bit 1 hidden
// RL16: three search-active flags at bits 2..0
// RL17: alarm-gone bits latch on falling condition
// RL18: RAI and AIS latch on rising condition
// RL19: latched bits clear only by writing one
// RL20: enabled set latched bit raises interrupt
// RL21: LOS and OOF latch on rising condition
// RL22: enable bit 0 masks, 1 allows
// RL23: interrupt is OR of enabled set bits
`timescale 1ns/1ps
module bfr_regs (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       e1_mode,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_rack,
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_chan_byte,
  input  wire logic [7:0] tx_serial_in,
  input  wire logic       tx_slot0,
  input  wire logic       tx_align_frame,
  input  wire logic       tx_crc_bit,
  input  wire logic [7:0] tx_align_word_reg,
  input  wire logic [7:0] tx_nonalign_word_reg,
  output logic [7:0]      tx_fmt_byte,
  output logic            tx_fmt_valid,
  output logic            tx_sf_mode,
  output logic            tx_crc4_active,
  input  wire logic       tx_line_valid,
  input  wire logic       tx_line_bit,
  output logic            line_pos,
  output logic            line_neg,
  input  wire logic [3:0] rx_live,
  input  wire logic [2:0] rx_search,
  input  wire logic       rx_mf_timeout,
  input  wire logic       rx_mf_synced,
  input  wire logic       rx_multiframe_check_en,
  input  wire logic       rx_status_three_pend,
  input  wire logic       rx_status_four_pend,
  output logic            irq_out
);
  localparam int NA = bfr_pkg::ALARM_N;

  // ************************************************************
  // register bank
  // ************************************************************
  logic [7:0] tx_common, tx_e1, irq_en, stat, rdata_d;
  logic [7:0] next_tx_common, next_tx_e1, next_irq_en, next_stat;
  logic [NA-1:0] live_q, next_live_q;
  logic [bfr_pkg::CSC_W-1:0] mf_search_counter, next_csc;
  logic bpv_pend, next_bpv_pend, bpv_done;
  logic [7:0] stat_set, sum, live_reg, sync_reg;
  logic wr_common, wr_e1, wr_stat;

  assign wr_common = reg_wr && reg_addr == bfr_pkg::OFS_TX_CONFIG_COMMON;
  assign wr_e1     = reg_wr && reg_addr == bfr_pkg::OFS_TX_CONFIG_E1;
  assign wr_stat   = reg_wr && reg_addr == bfr_pkg::OFS_RX_LATCHED_ALARMS;

  // edge detectors: falling edges land in the upper nibble
  genvar g;
  generate
    for (g = 0; g < NA; g++) begin : g_edge
      assign stat_set[g]    = rx_live[g] & ~live_q[g];                     // [RL18] [RL21]
      assign stat_set[g+NA] = ~rx_live[g] & live_q[g];                     // [RL17]
    end
  endgenerate

  always_comb begin
    next_tx_common = tx_common;
    next_tx_e1     = tx_e1;
    next_irq_en    = irq_en;
    next_live_q    = rx_live;
    if (wr_common) next_tx_common = reg_wdata & bfr_pkg::MASK_TX_COMMON; // [RL2]
    if (wr_e1) next_tx_e1 = reg_wdata & bfr_pkg::MASK_TX_E1;
    if (reg_wr && reg_addr == bfr_pkg::OFS_RX_IRQ_ENABLE_ONE) next_irq_en = reg_wdata; // [RL22]
    // a new event in the clearing cycle survives the clear
    next_stat = (stat & ~(wr_stat ? reg_wdata : bfr_pkg::ZERO_BYTE)) | stat_set; // [RL19]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_common <= bfr_pkg::RESET_BYTE;
      tx_e1     <= bfr_pkg::RESET_BYTE;
      irq_en    <= bfr_pkg::RESET_BYTE;
      stat      <= bfr_pkg::RESET_BYTE;
      live_q    <= '0;
    end else begin
      tx_common <= next_tx_common;
      tx_e1     <= next_tx_e1;
      irq_en    <= next_irq_en;
      stat      <= next_stat;
      live_q    <= next_live_q;
    end
  end

  // ************************************************************
  // sync counter, summary, interrupt
  // ************************************************************
  always_comb begin
    next_csc = mf_search_counter;
    if (!rx_multiframe_check_en || rx_mf_synced) next_csc = '0;         // [RL14]
    else if (e1_mode && rx_mf_timeout) next_csc = mf_search_counter + 1'b1;           // [RL13] [RL15]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) mf_search_counter <= '0;
    else mf_search_counter <= next_csc;
  end

  assign irq_out = |(stat & irq_en);                                    // [RL20] [RL23]

  always_comb begin
    sum = bfr_pkg::ZERO_BYTE;
    sum[bfr_pkg::BIT_SUM_STATUS_ONE]   = |(stat & irq_en);              // [RL9] [RL10] [RL11]
    sum[bfr_pkg::BIT_SUM_STATUS_THREE] = rx_status_three_pend;          // [RL9]
    sum[bfr_pkg::BIT_SUM_STATUS_FOUR]  = rx_status_four_pend;           // [RL9]
    live_reg = {4'h0, rx_live};                                         // [RL12]
    // counter bit 1 dropped so five bits span past 400 ms
    sync_reg = bfr_pkg::ZERO_BYTE;
    sync_reg[7:bfr_pkg::LSB_COUNT_FIELD] = {mf_search_counter[5:2], mf_search_counter[0]};          // [RL15]
    sync_reg[bfr_pkg::BIT_SEARCH_FRAME]    = rx_search[2];              // [RL16]
    sync_reg[bfr_pkg::BIT_SEARCH_SIG_MF]   = rx_search[1];              // [RL16]
    sync_reg[bfr_pkg::BIT_SEARCH_CHECK_MF] = rx_search[0];              // [RL16]
    case (reg_addr)
      bfr_pkg::OFS_TX_CONFIG_COMMON:  rdata_d = tx_common;
      bfr_pkg::OFS_TX_CONFIG_E1:      rdata_d = tx_e1;
      bfr_pkg::OFS_RX_IRQ_SUMMARY:    rdata_d = sum;
      bfr_pkg::OFS_RX_LIVE_ALARMS:    rdata_d = live_reg;
      bfr_pkg::OFS_RX_E1_SYNC_INFO:   rdata_d = sync_reg;
      bfr_pkg::OFS_RX_LATCHED_ALARMS: rdata_d = stat;
      bfr_pkg::OFS_RX_IRQ_ENABLE_ONE: rdata_d = irq_en;
      default:                        rdata_d = bfr_pkg::ZERO_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= bfr_pkg::ZERO_BYTE;
      reg_rack  <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : reg_rdata;
      reg_rack  <= reg_rd;
    end
  end

  // ************************************************************
  // transmit formatter
  // ************************************************************
  logic [7:0] fmt, next_fmt, slot0_src;
  logic next_fmt_valid, e1_ones, e1_crc, bpv_rise;

  assign e1_ones        = e1_mode && tx_e1[bfr_pkg::BIT_ALARM_ONES];
  assign e1_crc         = e1_mode && tx_e1[bfr_pkg::BIT_MF_CHECK_EN];
  assign tx_sf_mode     = !e1_mode && tx_common[bfr_pkg::BIT_FRAMING_SELECT]; // [RL2]
  assign tx_crc4_active = e1_crc;                                       // [RL8]
  assign bpv_rise = wr_common && reg_wdata[bfr_pkg::BIT_VIOLATION_INSERT]
                    && !tx_common[bfr_pkg::BIT_VIOLATION_INSERT];       // [RL3]

  always_comb begin
    slot0_src = tx_align_frame ? tx_align_word_reg : tx_nonalign_word_reg; // [RL4]
    if (!tx_e1[bfr_pkg::BIT_INTL_SOURCE])
      slot0_src[bfr_pkg::BIT_SI] = tx_serial_in[bfr_pkg::BIT_SI];       // [RL5]
    if (e1_crc && tx_align_frame)
      slot0_src[bfr_pkg::BIT_SI] = tx_crc_bit;                          // [RL8]
    next_fmt       = fmt;
    next_fmt_valid = tx_byte_valid;
    if (tx_byte_valid) begin
      next_fmt = tx_chan_byte;
      if (e1_ones) next_fmt = bfr_pkg::ALL_ONES_BYTE;                   // [RL7]
      else if (e1_mode && tx_slot0)
        next_fmt = tx_e1[bfr_pkg::BIT_SLOT0_PASS] ? tx_serial_in : slot0_src; // [RL4]
      else if (!e1_mode && tx_chan_byte == bfr_pkg::ZERO_BYTE && tx_common[0])
        next_fmt[bfr_pkg::BIT_ZERO_STUFF] = 1'b1;                       // [RL1]
    end
    next_bpv_pend = (bpv_pend && !bpv_done) || bpv_rise;                // [RL3]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fmt          <= bfr_pkg::ZERO_BYTE;
      tx_fmt_valid <= 1'b0;
      bpv_pend     <= 1'b0;
    end else begin
      fmt          <= next_fmt;
      tx_fmt_valid <= next_fmt_valid;
      bpv_pend     <= next_bpv_pend;
    end
  end
  assign tx_fmt_byte = fmt;

  // zero stuffing enable lives in bit 0 of the common register
  bfr_line_coder u_coder (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .line_valid (tx_line_valid),
    .line_bit   (tx_line_bit),
    .hdb3_en    (e1_mode && tx_e1[bfr_pkg::BIT_LINE_CODE_EN]),          // [RL6]
    .ones_en    (e1_ones),                                              // [RL7]
    .bpv_req    (bpv_pend),
    .bpv_done   (bpv_done),
    .line_pos   (line_pos),
    .line_neg   (line_neg)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_irq_or: assert property (irq_out == |(stat & irq_en)) else $error("irq mismatch"); // [RL23]
  chk_rise_rai: assert property ($rose(rx_live[3]) |=> stat[3]) else $error("rai not latched"); // [RL18]
  chk_fall_rai: assert property ($fell(rx_live[3]) |=> stat[7]) else $error("rai gone lost"); // [RL17]
  chk_rise_los: assert property ($rose(rx_live[1]) |=> stat[1]) else $error("los not latched"); // [RL21]
  chk_w1c_clear: assert property (wr_stat && reg_wdata[0] && !stat_set[0] |=> !stat[0])
    else $error("w1c failed"); // [RL19]
  chk_w0_keep: assert property (stat[2] && !reg_wdata[2] |=> stat[2]) else $error("bit lost"); // [RL19]
  chk_csc_clear: assert property (rx_mf_synced |=> mf_search_counter == '0) else $error("csc not cleared"); // [RL14]
  chk_csc_step: assert property (e1_mode && rx_mf_timeout && rx_multiframe_check_en && !rx_mf_synced
    |=> mf_search_counter == $past(mf_search_counter) + 6'd1) else $error("csc not stepped"); // [RL13]
  chk_ais_byte: assert property (tx_byte_valid && e1_ones |=> fmt == 8'hFF && tx_fmt_valid)
    else $error("ais byte"); // [RL7]
  chk_bpv_once: assert property (bpv_done |=> !bpv_pend) else $error("bpv repeated"); // [RL3]
  chk_sum_mask: assert property (irq_en == 8'h00 |-> !sum[0]) else $error("masked bit seen"); // [RL11]

  cov_irq: cover property ($rose(irq_out));
  cov_bpv: cover property (bpv_done);
  cov_wrap: cover property (mf_search_counter == 6'h3F && next_csc == 6'h00);
endmodule // bfr_regs

/* testbench/bfr_far_model.sv */
// bfr_far_model: receive framer side feeding live alarms, search flags, counter events
// assumes: bench calls its tasks one at a time; outputs move 1ns after mclk
`timescale 1ns/1ps
module bfr_far_model (
  input  wire logic mclk,
  output logic [3:0] rx_live,
  output logic [2:0] rx_search,
  output logic       rx_mf_timeout,
  output logic       rx_mf_synced,
  output logic       rx_multiframe_check_en
);
  initial begin
    {rx_live, rx_search, rx_mf_timeout, rx_mf_synced, rx_multiframe_check_en} = '0;
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic set_cond(input logic [3:0] live, input logic [2:0] srch, input logic chk_en);
    step();
    rx_live = live;
    rx_search = srch;
    rx_multiframe_check_en = chk_en;
  endtask

  // ****************
  // window expiries
  // ****************
  // gap between pulses so a level reading cannot double count
  task automatic expire(input int n);
    repeat (n) begin
      step();
      rx_mf_timeout = 1'b1;
      step();
      rx_mf_timeout = 1'b0;
    end
  endtask

  task automatic sync_hit();
    step();
    rx_mf_synced = 1'b1;
    step();
    rx_mf_synced = 1'b0;
  endtask
endmodule // bfr_far_model

/* testbench/bfr_regs_tb.sv */
// bfr_regs_tb: self-checking bench, bench acts as host and transmit source
// assumes: bfr_far_model stands in for the receive framer
`timescale 1ns/1ps
module bfr_regs_tb;
  logic        mclk, reset_n, e1_mode, reg_wr, reg_rd, reg_rack;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, tx_chan_byte, tx_serial_in, tx_fmt_byte;
  logic        tx_byte_valid, tx_slot0, tx_align_frame, tx_crc_bit, tx_fmt_valid;
  logic [7:0]  tx_align_word_reg, tx_nonalign_word_reg;
  logic        tx_sf_mode, tx_crc4_active, tx_line_valid, tx_line_bit, line_pos, line_neg;
  logic [3:0]  rx_live;
  logic [2:0]  rx_search;
  logic        rx_mf_timeout, rx_mf_synced, chk_en, pend3, pend4, irq_out;
  int          err_total, check_count, pulses, n;
  logic [31:0] lfsr;
  logic [7:0]  rq[$];
  logic [7:0]  fq[$];
  logic [7:0]  map[8] = '{8'h29, 8'h2A, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h40};

  bfr_regs dut (.mclk(mclk), .reset_n(reset_n), .e1_mode(e1_mode), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rack(reg_rack), .tx_byte_valid(tx_byte_valid), .tx_chan_byte(tx_chan_byte),
    .tx_serial_in(tx_serial_in), .tx_slot0(tx_slot0), .tx_align_frame(tx_align_frame),
    .tx_crc_bit(tx_crc_bit), .tx_align_word_reg(tx_align_word_reg),
    .tx_nonalign_word_reg(tx_nonalign_word_reg), .tx_fmt_byte(tx_fmt_byte),
    .tx_fmt_valid(tx_fmt_valid), .tx_sf_mode(tx_sf_mode), .tx_crc4_active(tx_crc4_active),
    .tx_line_valid(tx_line_valid), .tx_line_bit(tx_line_bit), .line_pos(line_pos),
    .line_neg(line_neg), .rx_live(rx_live), .rx_search(rx_search), .rx_mf_timeout(rx_mf_timeout),
    .rx_mf_synced(rx_mf_synced), .rx_multiframe_check_en(chk_en),
    .rx_status_three_pend(pend3), .rx_status_four_pend(pend4), .irq_out(irq_out));

  bfr_far_model far (.mclk(mclk), .rx_live(rx_live), .rx_search(rx_search),
    .rx_mf_timeout(rx_mf_timeout), .rx_mf_synced(rx_mf_synced), .rx_multiframe_check_en(chk_en));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ****************
  // host cycles, strobe dropped for a full cycle between transfers
  // ****************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rq.push_back(exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    tick();
  endtask

  task automatic fmt(input logic s0, input logic [7:0] b, input logic [7:0] exp);
    fq.push_back(exp);
    tx_slot0 = s0;
    tx_chan_byte = b;
    tx_byte_valid = 1'b1;
    tick();
    tx_byte_valid = 1'b0;
    tick();
  endtask

  task automatic line_run(input logic [7:0] cfg, output int cnt);
    wr(8'h2A, cfg);
    tx_line_valid = 1'b1;
    repeat (8) tick();
    pulses = 0;
    repeat (24) tick();
    cnt = pulses;
    tx_line_valid = 1'b0;
  endtask

  // ****************
  // result watcher: oldest note against each answer
  // ****************
  // mid-cycle sampling keeps registered outputs clear of the launching edge
  always @(negedge mclk) begin
    if (reg_rack === 1'b1)
      chk(reg_rdata, (rq.size() > 0) ? rq.pop_front() : 8'hXX);
    if (tx_fmt_valid === 1'b1)
      chk(tx_fmt_byte, (fq.size() > 0) ? fq.pop_front() : 8'hXX);
    if (line_pos === 1'b1 || line_neg === 1'b1)
      pulses++;
  end

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // about 355 cycles expected, generous margin
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata, tx_byte_valid, tx_chan_byte, tx_serial_in} = '0;
    {tx_slot0, tx_align_frame, tx_crc_bit, tx_line_valid, tx_line_bit, pend3, pend4, e1_mode} = '0;
    tx_align_word_reg = 8'h1B;
    tx_nonalign_word_reg = 8'h40;
    {err_total, check_count, pulses} = '0;
    lfsr = 32'h112E;
    reset_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    tick();
    foreach (map[i]) rd(map[i], 8'h00);
    wr(8'h29, 8'hFF);
    rd(8'h29, 8'h06);
    chk({7'h0, tx_sf_mode}, 8'h01);
    wr(8'h29, 8'h00);
    e1_mode = 1'b1;
    wr(8'h2A, 8'hFF);
    rd(8'h2A, 8'h97);
    chk({7'h0, tx_crc4_active}, 8'h01);
    e1_mode = 1'b0;
    #1;
    chk({7'h0, tx_crc4_active}, 8'h00);
    e1_mode = 1'b1;
    lfsr = lfsr_next(lfsr);
    wr(8'h2A, 8'h02);
    fmt(1'b0, lfsr[7:0], 8'hFF);
    wr(8'h2A, 8'h80);
    tx_serial_in = lfsr[15:8];
    fmt(1'b1, lfsr[7:0], lfsr[15:8]);
    wr(8'h2A, 8'h10);
    tx_align_frame = 1'b1;
    fmt(1'b1, lfsr[7:0], 8'h1B);
    tx_align_frame = 1'b0;
    fmt(1'b1, lfsr[7:0], 8'h40);
    wr(8'h2A, 8'h00);
    fmt(1'b0, lfsr[7:0], lfsr[7:0]);
    e1_mode = 1'b0;
    fmt(1'b0, 8'h00, 8'h00);
    e1_mode = 1'b1;
    line_run(8'h00, n);
    chk(8'(n == 0), 8'h01);
    line_run(8'h04, n);
    chk(8'(n > 0), 8'h01);
    line_run(8'h02, n);
    chk(8'(n >= 20), 8'h01);
    wr(8'h2A, 8'h00);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      far.set_cond(lfsr[3:0], 3'b000, 1'b0);
      rd(8'h31, {4'h0, lfsr[3:0]});
    end
    far.set_cond(4'h0, 3'b101, 1'b0);
    // let the edge events latch before the clear, else set wins
    tick();
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h00);
    rd(8'h32, 8'h05);
    far.set_cond(4'hF, 3'b010, 1'b0);
    tick();
    rd(8'h33, 8'h0F);
    rd(8'h32, 8'h02);
    far.set_cond(4'h0, 3'b000, 1'b0);
    tick();
    rd(8'h33, 8'hFF);
    wr(8'h33, 8'h00);
    rd(8'h33, 8'hFF);
    chk({7'h0, irq_out}, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h34, 8'h10);
    chk({7'h0, irq_out}, 8'h01);
    rd(8'h30, 8'h01);
    pend3 = 1'b1;
    pend4 = 1'b1;
    rd(8'h30, 8'h43);
    pend3 = 1'b0;
    pend4 = 1'b0;
    wr(8'h33, 8'h10);
    chk({7'h0, irq_out}, 8'h00);
    rd(8'h33, 8'hEF);
    rd(8'h30, 8'h00);
    far.set_cond(4'h0, 3'b000, 1'b1);
    far.expire(7);
    rd(8'h32, 8'h18);
    far.expire(59);
    rd(8'h32, 8'h00);
    far.expire(1);
    rd(8'h32, 8'h08);
    far.sync_hit();
    rd(8'h32, 8'h00);
    far.expire(1);
    far.set_cond(4'h0, 3'b000, 1'b0);
    tick();
    rd(8'h32, 8'h00);
    report_and_stop();
  end
endmodule // bfr_regs_tb
